// [design/sbh_master.sv]
// Bus master end: bus clock, transfers, arbitration and bus handover
// Operation
// - Response lines read only in bus clock low phase
// - Response codes ready, last, wait, address hold
// - Slave keeps hold until wait line drops
// - Slave never returns from hold to wait
// - Write direction high throughout write access only
// - Read path control high during reads
// - Write path control high during writes
// - Read data presented after address, sampled falling
// - After hold, read data sampled next falling edge
// - Write data driven falling edge after address
// - Bus clock held low through reset
// - Priority hold, refresh, DMA, operand, fetch
// - Owner waits for ready or last before giving bus
// - Slave returns ready, or last if cfg_last, when transfer completes
// - Handover shows address-only, selects and lock negated
// - Grant returned with ready response to requester
// - Ready only when all three lines low
// - Type codes 00 address-only, 10, 11
// - Timer master above external above interior master
`timescale 1ns/10ps
module sbh_master (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ce,
   sbh_if.master bus,
   input wire logic [sbh_pkg::NSRC-1:0] src_req,
   input wire logic [sbh_pkg::NSRC-1:0] src_write,
   input wire logic [sbh_pkg::NSRC-1:0] src_seq,
   input wire logic [sbh_pkg::NSRC-1:0] src_lock,
   input wire logic [sbh_pkg::NSRC-1:0] src_periph,
   input wire logic [sbh_pkg::NSRC-1:0][sbh_pkg::ADDR_W-1:0] src_addr,
   input wire logic [sbh_pkg::NSRC-1:0][sbh_pkg::DATA_W-1:0] src_wdata,
   output logic [sbh_pkg::NSRC-1:0] src_ack,
   output logic [sbh_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic wr_done,
   output logic resp_reserved,
   input wire logic tic_req,
   output logic tic_grant
);
   import sbh_pkg::*;

   typedef enum logic [3:0] {
      MS_IDLE = 4'h1,
      MS_ADDR = 4'h2,
      MS_RESP = 4'h4,
      MS_GRANT = 4'h8
   } sbh_mst_state_type;

   typedef struct packed {
      sbh_mst_state_type st;
      logic bclk;
      logic [1:0] ttype;
      logic wr;
      logic rdp;
      logic wrp;
      logic lock;
      logic [CS_W-1:0] cs_n;
      logic ps_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wbuf;
      logic [DATA_W-1:0] wdo;
      logic [DATA_W-1:0] rcap;
      logic [2:0] rsp_out;
      logic grant_ext;
      logic grant_tic;
      logic [NSRC-1:0] ack;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic wdone;
      logic rsv;
   } sbh_mst_type;

   sbh_mst_type mst_reg;
   sbh_mst_type mst_next;
   logic rise;
   logic fall;
   logic [2:0] rsp;
   logic any_req;
   logic [2:0] pidx;

   // Highest set request wins; top index is bus hold
   function automatic logic [2:0] prio_idx(input logic [NSRC-1:0] req);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 0; i < NSRC; i++) begin
         if (req[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Low phase ends at the next edge, which is the bus clock rising edge
   assign rise = ~mst_reg.bclk;
   assign fall = mst_reg.bclk;
   assign rsp = {bus.resp_wait_in, bus.resp_addr_hold_in, bus.resp_last_in};
   assign any_req = src_req != '0;
   assign pidx = prio_idx(src_req);

   always_comb begin
      mst_next = mst_reg;
      mst_next.bclk = ~mst_reg.bclk;
      mst_next.ack = '0;
      mst_next.rvalid = 1'b0;
      mst_next.wdone = 1'b0;
      mst_next.rsv = 1'b0;
      unique case (mst_reg.st)
         MS_IDLE: begin
            if (rise) begin
               if (tic_req || bus.access_request) begin
                  // Bus is free here: the last transfer already saw ready or last
                  mst_next.st = MS_GRANT;
                  mst_next.grant_tic = tic_req;
                  mst_next.grant_ext = !tic_req;
                  mst_next.rsp_out = RESP_READY;
               end else if (any_req) begin
                  mst_next.st = MS_ADDR;
                  mst_next.ack[pidx] = 1'b1;
                  mst_next.addr = src_addr[pidx];
                  mst_next.wbuf = src_wdata[pidx];
                  mst_next.ttype = src_seq[pidx] ? TT_SEQ : TT_NONSEQ;
                  mst_next.wr = src_write[pidx];
                  mst_next.rdp = !src_write[pidx];
                  mst_next.wrp = src_write[pidx];
                  mst_next.lock = src_lock[pidx];
                  mst_next.ps_n = !src_periph[pidx];
                  mst_next.cs_n = src_periph[pidx] ? CS_NONE :
                     area_cs_n(src_addr[pidx]);
               end
            end
         end
         MS_ADDR: begin
            if (fall) begin
               mst_next.st = MS_RESP;
               if (mst_reg.wr) begin
                  mst_next.wdo = mst_reg.wbuf;
               end
            end
         end
         MS_RESP: begin
            if (fall) begin
               mst_next.rcap = bus.read_data_bus;
            end
            if (rise) begin
               if (!resp_is_legal(rsp)) begin
                  mst_next.rsv = 1'b1;
               end
               if (resp_is_done(rsp)) begin
                  mst_next.st = MS_IDLE;
                  mst_next.rdata = mst_reg.wr ? mst_reg.rdata : mst_reg.rcap;
                  mst_next.rvalid = !mst_reg.wr;
                  mst_next.wdone = mst_reg.wr;
                  mst_next.ttype = TT_ADDR_ONLY;
                  mst_next.wr = 1'b0;
                  mst_next.rdp = 1'b0;
                  mst_next.wrp = 1'b0;
                  mst_next.lock = 1'b0;
                  mst_next.cs_n = CS_NONE;
                  mst_next.ps_n = 1'b1;
               end
            end
         end
         MS_GRANT: begin
            // Interior master requests again as soon as the bus comes back
            if (rise) begin
               if ((mst_reg.grant_tic && !tic_req) ||
                   (mst_reg.grant_ext && !bus.access_request)) begin
                  mst_next.st = MS_IDLE;
                  mst_next.grant_tic = 1'b0;
                  mst_next.grant_ext = 1'b0;
                  mst_next.rsp_out = RESP_WAIT;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mst_reg <= '0;
         mst_reg.st <= MS_IDLE;
         mst_reg.ttype <= TT_ADDR_ONLY;
         mst_reg.cs_n <= CS_NONE;
         mst_reg.ps_n <= 1'b1;
         mst_reg.rsp_out <= RESP_WAIT;
      end else if (ce) begin
         mst_reg <= mst_next;
      end
   end

   assign bus.bus_clock = mst_reg.bclk;
   assign bus.resp_wait_out = mst_reg.rsp_out[2];
   assign bus.resp_addr_hold_out = mst_reg.rsp_out[1];
   assign bus.resp_last_out = mst_reg.rsp_out[0];
   assign bus.write_direction = mst_reg.wr;
   assign bus.read_path_ctrl = mst_reg.rdp;
   assign bus.write_path_ctrl = mst_reg.wrp;
   assign bus.write_data_bus = mst_reg.wdo;
   assign bus.access_grant = mst_reg.grant_ext;
   assign bus.transfer_type_hi = mst_reg.ttype[1];
   assign bus.transfer_type_lo = mst_reg.ttype[0];
   assign bus.bus_lock = mst_reg.lock;
   assign bus.area_chip_select_n = mst_reg.cs_n;
   assign bus.periph_select_n = mst_reg.ps_n;
   assign bus.bus_addr = mst_reg.addr;
   assign src_ack = mst_reg.ack;
   assign rd_data = mst_reg.rdata;
   assign rd_valid = mst_reg.rvalid;
   assign wr_done = mst_reg.wdone;
   assign resp_reserved = mst_reg.rsv;
   assign tic_grant = mst_reg.grant_tic;
endmodule

// [design/sbh_pkg.sv]
// Shared constants and helpers for the system bus handshake ends
package sbh_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 28;
   localparam int NSRC = 5;
   localparam int CS_W = 8;
   localparam int CNT_W = 4;
   // Source index of interior cycle kinds, highest priority first
   localparam int SRC_BUS_HOLD = 4;
   localparam int SRC_REFRESH = 3;
   localparam int SRC_DMA = 2;
   localparam int SRC_OPERAND = 1;
   localparam int SRC_FETCH = 0;
   // Transfer type codes {hi, lo}
   localparam logic [1:0] TT_ADDR_ONLY = 2'h0;
   localparam logic [1:0] TT_RESERVED = 2'h1;
   localparam logic [1:0] TT_NONSEQ = 2'h2;
   localparam logic [1:0] TT_SEQ = 2'h3;
   // Response codes {wait, addr_hold, last}
   localparam logic [2:0] RESP_READY = 3'h0;
   localparam logic [2:0] RESP_LAST = 3'h1;
   localparam logic [2:0] RESP_WAIT = 3'h4;
   localparam logic [2:0] RESP_HOLD = 3'h6;
   // Chip select levels
   localparam logic [CS_W-1:0] CS_NONE = 8'hFF;
   localparam logic [CS_W-1:0] SLV_CS_MASK = 8'h3F;
   localparam int AREA_W = 3;

   // Ready only when all three response lines are low
   function automatic logic resp_is_ready(input logic [2:0] rsp);
      return rsp == RESP_READY;
   endfunction

   // A transfer ends on ready or on the last burst response
   function automatic logic resp_is_done(input logic [2:0] rsp);
      return (rsp == RESP_READY) || (rsp == RESP_LAST);
   endfunction

   function automatic logic resp_is_legal(input logic [2:0] rsp);
      return (rsp == RESP_READY) || (rsp == RESP_LAST) ||
             (rsp == RESP_WAIT) || (rsp == RESP_HOLD);
   endfunction

   // Active-low select of the data area named by the top address bits
   function automatic logic [CS_W-1:0] area_cs_n(
      input logic [ADDR_W-1:0] addr);
      return ~(8'h01 << addr[ADDR_W-1 -: AREA_W]);
   endfunction
endpackage

// [design/sbh_if.sv]
// System bus wires between the owning master and the slave side
`timescale 1ns/10ps
interface sbh_if;
   import sbh_pkg::*;
   logic bus_clock;
   logic resp_wait_in;
   logic resp_addr_hold_in;
   logic resp_last_in;
   logic resp_wait_out;
   logic resp_addr_hold_out;
   logic resp_last_out;
   logic write_direction;
   logic read_path_ctrl;
   logic write_path_ctrl;
   logic [DATA_W-1:0] read_data_bus;
   logic [DATA_W-1:0] write_data_bus;
   logic access_request;
   logic access_grant;
   logic transfer_type_hi;
   logic transfer_type_lo;
   logic bus_lock;
   logic [CS_W-1:0] area_chip_select_n;
   logic periph_select_n;
   logic [ADDR_W-1:0] bus_addr;

   modport master (
      output bus_clock,
      input resp_wait_in,
      input resp_addr_hold_in,
      input resp_last_in,
      output resp_wait_out,
      output resp_addr_hold_out,
      output resp_last_out,
      output write_direction,
      output read_path_ctrl,
      output write_path_ctrl,
      input read_data_bus,
      output write_data_bus,
      input access_request,
      output access_grant,
      output transfer_type_hi,
      output transfer_type_lo,
      output bus_lock,
      output area_chip_select_n,
      output periph_select_n,
      output bus_addr
   );

   modport slave (
      input bus_clock,
      output resp_wait_in,
      output resp_addr_hold_in,
      output resp_last_in,
      input resp_wait_out,
      input resp_addr_hold_out,
      input resp_last_out,
      input write_direction,
      input read_path_ctrl,
      input write_path_ctrl,
      output read_data_bus,
      input write_data_bus,
      output access_request,
      input access_grant,
      input transfer_type_hi,
      input transfer_type_lo,
      input bus_lock,
      input area_chip_select_n,
      input periph_select_n,
      input bus_addr
   );
endinterface

// [design/sbh_slave.sv]
// Bus slave end: transfer responses, read data and an external requester
`timescale 1ns/10ps
module sbh_slave (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ce,
   sbh_if.slave bus,
   input wire logic [sbh_pkg::CNT_W-1:0] cfg_waits,
   input wire logic [sbh_pkg::CNT_W-1:0] cfg_holds,
   input wire logic cfg_last,
   input wire logic [sbh_pkg::DATA_W-1:0] rd_data,
   input wire logic ext_req,
   output logic ext_granted,
   output logic [sbh_pkg::DATA_W-1:0] wr_data,
   output logic wr_strobe,
   output logic rd_strobe
);
   import sbh_pkg::*;

   typedef enum logic [3:0] {
      SS_IDLE = 4'h1,
      SS_WAIT = 4'h2,
      SS_HOLD = 4'h4,
      SS_DONE = 4'h8
   } sbh_slv_state_type;

   typedef struct packed {
      sbh_slv_state_type st;
      logic [CNT_W-1:0] cnt;
      logic [2:0] rsp;
      logic [DATA_W-1:0] rdbus;
      logic [DATA_W-1:0] wdat;
      logic wstb;
      logic rstb;
      logic req;
      logic granted;
   } sbh_slv_type;

   sbh_slv_type slv_reg;
   sbh_slv_type slv_next;
   logic rise;
   logic selected;
   logic [2:0] grant_rsp;

   // Slave moves on the bus clock rising edge, at the end of the low phase
   assign rise = ~bus.bus_clock;
   assign selected = bus.transfer_type_hi &&
      (((~bus.area_chip_select_n & SLV_CS_MASK) != '0) ||
       !bus.periph_select_n);
   assign grant_rsp = {bus.resp_wait_out, bus.resp_addr_hold_out,
                       bus.resp_last_out};

   always_comb begin
      slv_next = slv_reg;
      slv_next.wstb = 1'b0;
      slv_next.rstb = 1'b0;
      slv_next.req = ext_req;
      slv_next.granted = bus.access_grant && resp_is_ready(grant_rsp);
      if (rise) begin
         unique case (slv_reg.st)
            SS_IDLE: begin
               if (selected) begin
                  slv_next.rdbus = rd_data;
                  if (cfg_waits != '0) begin
                     slv_next.st = SS_WAIT;
                     slv_next.cnt = cfg_waits;
                     slv_next.rsp = RESP_WAIT;
                  end else if (cfg_holds != '0) begin
                     slv_next.st = SS_HOLD;
                     slv_next.cnt = cfg_holds;
                     slv_next.rsp = RESP_HOLD;
                  end else begin
                     slv_next.st = SS_DONE;
                  end
               end
            end
            SS_WAIT: begin
               slv_next.cnt = slv_reg.cnt - 1'b1;
               if (slv_reg.cnt == 4'h1) begin
                  if (cfg_holds != '0) begin
                     slv_next.st = SS_HOLD;
                     slv_next.cnt = cfg_holds;
                     slv_next.rsp = RESP_HOLD;
                  end else begin
                     slv_next.st = SS_DONE;
                  end
               end
            end
            SS_HOLD: begin
               // Hold stays up until the wait line drops; never back to wait
               slv_next.rdbus = rd_data;
               slv_next.cnt = slv_reg.cnt - 1'b1;
               if (slv_reg.cnt == 4'h1) begin
                  slv_next.st = SS_DONE;
               end
            end
            SS_DONE: begin
               slv_next.st = SS_IDLE;
               slv_next.rsp = RESP_WAIT;
            end
         endcase
         // Finish: ready or last response once the transfer is complete
         if (slv_next.st == SS_DONE && slv_reg.st != SS_DONE) begin
            slv_next.rsp = cfg_last ? RESP_LAST : RESP_READY;
            slv_next.wdat = bus.write_direction ?
               bus.write_data_bus : slv_reg.wdat;
            slv_next.wstb = bus.write_direction;
            slv_next.rstb = !bus.write_direction;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         slv_reg <= '0;
         slv_reg.st <= SS_IDLE;
         slv_reg.rsp <= RESP_WAIT;
      end else if (ce) begin
         slv_reg <= slv_next;
      end
   end

   assign bus.resp_wait_in = slv_reg.rsp[2];
   assign bus.resp_addr_hold_in = slv_reg.rsp[1];
   assign bus.resp_last_in = slv_reg.rsp[0];
   assign bus.read_data_bus = slv_reg.rdbus;
   assign bus.access_request = slv_reg.req;
   assign ext_granted = slv_reg.granted;
   assign wr_data = slv_reg.wdat;
   assign wr_strobe = slv_reg.wstb;
   assign rd_strobe = slv_reg.rstb;
endmodule

// [tb/sbh_monitor.sv]
// Concurrent checks on the system bus wires between the two ends
`timescale 1ns/10ps
module sbh_monitor (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic bus_clock,
   input wire logic resp_wait_in,
   input wire logic resp_addr_hold_in,
   input wire logic resp_last_in,
   input wire logic resp_wait_out,
   input wire logic resp_addr_hold_out,
   input wire logic resp_last_out,
   input wire logic write_direction,
   input wire logic read_path_ctrl,
   input wire logic write_path_ctrl,
   input wire logic access_request,
   input wire logic access_grant,
   input wire logic transfer_type_hi,
   input wire logic transfer_type_lo,
   input wire logic bus_lock,
   input wire logic [sbh_pkg::CS_W-1:0] area_chip_select_n
);
   import sbh_pkg::*;
   logic busy;
   logic [2:0] rsp;
   assign busy = read_path_ctrl | write_path_ctrl;
   assign rsp = {resp_wait_in, resp_addr_hold_in, resp_last_in};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Completion seen in the low phase
   sequence s_low_done;
      busy && !bus_clock && (rsp == RESP_READY || rsp == RESP_LAST);
   endsequence
   sequence s_hold;
      rsp == RESP_HOLD;
   endsequence
   a_clock_runs: assert property (!srst |=>
      bus_clock != $past(bus_clock))
      else $error("bus clock stopped");
   a_resp_legal: assert property (
      rsp == RESP_READY || rsp == RESP_LAST ||
      rsp == RESP_WAIT || rsp == RESP_HOLD)
      else $error("reserved response code");
   a_hold_kept: assert property (s_hold |=> rsp != RESP_WAIT)
      else $error("hold fell back to wait");
   a_wait_keeps: assert property (
      busy && (bus_clock || resp_wait_in || resp_addr_hold_in) |=> busy)
      else $error("transfer ended without ready");
   a_done_ends: assert property (
      s_low_done |=> !busy && !transfer_type_hi)
      else $error("transfer not ended after ready");
   a_write_dir: assert property (
      write_direction == write_path_ctrl &&
      !(read_path_ctrl && write_path_ctrl))
      else $error("direction and path control disagree");
   a_path_typed: assert property (busy |-> transfer_type_hi)
      else $error("access without transfer type");
   a_type_legal: assert property (
      !(!transfer_type_hi && transfer_type_lo))
      else $error("reserved transfer type");
   a_grant_clean: assert property (
      access_grant |-> !busy && !bus_lock &&
      {transfer_type_hi, transfer_type_lo} == TT_ADDR_ONLY &&
      area_chip_select_n == CS_NONE &&
      {resp_wait_out, resp_addr_hold_out, resp_last_out} == RESP_READY)
      else $error("handover signals wrong");
   a_grant_cause: assert property ($rose(access_grant) |->
      $past(access_request) && !$past(busy))
      else $error("grant without request or while busy");
   a_grant_drop: assert property (access_grant && !access_request &&
      !bus_clock |=> !access_grant)
      else $error("grant kept after request dropped");
endmodule

// [tb/system_bus_transfer_handshake_tb.sv]
// Self-checking bench joining master and slave ends over the system bus
`timescale 1ns/10ps
module system_bus_transfer_handshake_tb;
   import sbh_pkg::*;
   logic ref_clk, srst, tic_req, tic_grant, ext_req, ext_granted;
   logic [NSRC-1:0] src_req, src_write, src_seq, src_lock, src_periph;
   logic [NSRC-1:0] src_ack;
   logic [NSRC-1:0][ADDR_W-1:0] src_addr;
   logic [NSRC-1:0][DATA_W-1:0] src_wdata;
   logic [DATA_W-1:0] m_rd_data, rd_in, wr_data, wr_cap;
   logic rd_valid, wr_done, wr_strobe, cfg_last, rsv_pulse;
   logic [CNT_W-1:0] cfg_waits, cfg_holds;
   int err_count = 0;
   int num_checks = 0;
   int tw[5] = '{0, 2, 1, 0, 3};
   int th[5] = '{0, 0, 2, 3, 1};
   sbh_if bus ();
   sbh_master u_sbh_master (.ref_clk(ref_clk), .srst(srst), .ce(1'b1),
      .bus(bus), .src_req(src_req), .src_write(src_write),
      .src_seq(src_seq), .src_lock(src_lock), .src_periph(src_periph),
      .src_addr(src_addr), .src_wdata(src_wdata), .src_ack(src_ack),
      .rd_data(m_rd_data), .rd_valid(rd_valid), .wr_done(wr_done),
      .resp_reserved(rsv_pulse), .tic_req(tic_req), .tic_grant(tic_grant));
   sbh_slave u_sbh_slave (.ref_clk(ref_clk), .srst(srst), .ce(1'b1),
      .bus(bus), .cfg_waits(cfg_waits), .cfg_holds(cfg_holds),
      .cfg_last(cfg_last), .rd_data(rd_in), .ext_req(ext_req),
      .ext_granted(ext_granted), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe());
   sbh_monitor u_sbh_monitor (.ref_clk(ref_clk), .srst(srst),
      .bus_clock(bus.bus_clock), .resp_wait_in(bus.resp_wait_in),
      .resp_addr_hold_in(bus.resp_addr_hold_in),
      .resp_last_in(bus.resp_last_in), .resp_wait_out(bus.resp_wait_out),
      .resp_addr_hold_out(bus.resp_addr_hold_out),
      .resp_last_out(bus.resp_last_out),
      .write_direction(bus.write_direction),
      .read_path_ctrl(bus.read_path_ctrl),
      .write_path_ctrl(bus.write_path_ctrl),
      .access_request(bus.access_request),
      .access_grant(bus.access_grant),
      .transfer_type_hi(bus.transfer_type_hi),
      .transfer_type_lo(bus.transfer_type_lo), .bus_lock(bus.bus_lock),
      .area_chip_select_n(bus.area_chip_select_n));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (wr_strobe === 1'b1)
         wr_cap <= wr_data;
      // Slave never sends a reserved code, so the master must not flag one
      if (rsv_pulse !== 1'b0 && !srst) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, rsv_pulse, 1'b0);
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait: 0 ack, 1 completion, 2 timer grant, 3 external grant
   task automatic wait_sig(input int sel);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (!(sel == 0 ? src_ack != '0 : sel == 1 ?
         (rd_valid | wr_done) : sel == 2 ? tic_grant : ext_granted)
         && n < 200);
      chk(32'(n >= 200), 32'h0);
   endtask

   task automatic xfer(input int i, input logic wr, input logic [2:0] f,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      src_req[i] <= 1'b1;
      src_write[i] <= wr;
      {src_periph[i], src_lock[i], src_seq[i]} <= f;
      src_addr[i] <= a;
      src_wdata[i] <= d;
      rd_in <= d;
      wait_sig(0);
      chk(32'(src_ack), 32'(1 << i));
      chk(32'({bus.transfer_type_hi, bus.transfer_type_lo}),
         32'({1'b1, f[0]}));
      chk(32'({bus.write_direction, bus.read_path_ctrl}),
         32'({wr, ~wr}));
      @(posedge ref_clk);
      src_req[i] <= 1'b0;
      wait_sig(1);
      chk(32'({rd_valid, wr_done}), 32'({~wr, wr}));
      chk({23'h0, bus.periph_select_n, bus.area_chip_select_n},
         32'h1FF);
      if (wr)
         chk(wr_cap, d);
      else
         chk(m_rd_data, d);
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      #50000;
      err_count++;
      conclude();
   end

   initial begin
      srst = 1'b1;
      {src_req, src_write, src_seq, src_lock, src_periph} = '0;
      src_addr = '0;
      src_wdata = '0;
      {rd_in, tic_req, ext_req, cfg_last} = '0;
      cfg_waits = '0;
      cfg_holds = '0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      for (int j = 0; j < 5; j++) begin
         for (int w = 0; w < 2; w++) begin
            @(posedge ref_clk);
            cfg_waits <= CNT_W'(tw[j]);
            cfg_holds <= CNT_W'(th[j]);
            cfg_last <= (j == 3);
            xfer(j, w[0], 3'(j), {3'(j), 25'h40},
               {8'hA5, 8'(j), 8'(w), 8'h3C});
         end
      end
      @(posedge ref_clk);
      {cfg_waits, cfg_holds, cfg_last} <= '0;
      src_req <= '1;
      src_write <= '0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         wait_sig(0);
         chk(32'(src_ack), 32'(1 << k));
         @(posedge ref_clk);
         src_req[k] <= 1'b0;
      end
      wait_sig(1);
      @(posedge ref_clk);
      cfg_waits <= 4'h3;
      fork
         xfer(1, 1'b0, 3'h0, 28'h0000080, 32'h5A5A0F0F);
         begin
            repeat (5) @(posedge ref_clk);
            ext_req <= 1'b1;
            tic_req <= 1'b1;
         end
      join
      wait_sig(2);
      chk(32'({tic_grant, bus.access_grant, ext_granted}), 32'h4);
      @(posedge ref_clk);
      tic_req <= 1'b0;
      wait_sig(3);
      chk(32'({bus.access_grant, tic_grant, bus.resp_wait_out}), 32'h4);
      @(posedge ref_clk);
      ext_req <= 1'b0;
      xfer(0, 1'b1, 3'h2, 28'hA000100, 32'hC3C31234);
      conclude();
   end
endmodule
